/* File: hdl/drt_cmd_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module drt_cmd_decode
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Command pins
    input  wire logic                       cke,
    input  wire logic                       cs_n,
    input  wire logic                       ras_n,
    input  wire logic                       cas_n,
    input  wire logic                       we_n,
    input  wire logic [drt_pkg::BANK_W-1:0] ba,
    input  wire logic                       a10,
    // Decoded strobes
    drt_cmd_if.dec                          cmd
);
    logic cke_prev;

    // Previous-cycle CKE; reset low so nothing decodes before CKE rises
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cke_prev <= 1'b0;
        else
            cke_prev <= cke;
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire nop_or_des = cs_n | (ras_n & cas_n & we_n);
    wire refresh_code = !cs_n & !ras_n & !cas_n & we_n;
    wire cke_hh = cke_prev & cke;
    wire cke_fall = cke_prev & !cke;

    assign cmd.is_refresh = cke_hh & refresh_code;
    assign cmd.is_sref_entry = cke_fall & refresh_code;
    assign cmd.is_pd_entry = cke_fall & nop_or_des;
    // Self-refresh exit is asynchronous, so any CKE rise counts
    assign cmd.is_cke_rise = !cke_prev & cke;
    assign cmd.is_activate = cke_hh & !cs_n & !ras_n & cas_n & we_n;
    assign cmd.is_precharge = cke_hh & !cs_n & !ras_n & cas_n & !we_n;
    assign cmd.pre_all = a10;
    assign cmd.bank = ba;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_arf_decode;
        @(posedge sys_clk) disable iff (!rst_n)
        (cke && $past(cke) && !cs_n && !ras_n && !cas_n && we_n)
            |-> cmd.is_refresh && !cmd.is_precharge;
    endproperty
    a_arf_decode: assert property (p_arf_decode)
        else $error("refresh code not decoded");

    property p_pd_code;
        @(posedge sys_clk) disable iff (!rst_n)
        ($fell(cke) && (cs_n || (ras_n && cas_n && we_n)))
            |-> cmd.is_pd_entry && !cmd.is_sref_entry;
    endproperty
    a_pd_code: assert property (p_pd_code)
        else $error("deselect with CKE low not power-down");
endmodule
`default_nettype wire

/* File: hdl/drt_timing_core.sv */
`timescale 1ns/1ns
`default_nettype none
module drt_timing_core
(
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // Command pins
    input  wire logic                          cke,
    input  wire logic                          cs_n,
    input  wire logic                          ras_n,
    input  wire logic                          cas_n,
    input  wire logic                          we_n,
    input  wire logic                          odt,
    input  wire logic [drt_pkg::BANK_W-1:0]    ba,
    input  wire logic                          a10,
    // Mode setting
    input  wire logic                          active_pd_exit_select_bit,
    // Power state
    output logic                               in_sref,
    output logic                               in_pd,
    output logic                               active_pd,
    output logic                               slow_exit_pd,
    output logic                               dll_enabled,
    output logic                               input_buffers_on,
    output logic                               odt_term_on,
    // Refresh and bank status
    output logic                               refresh_busy,
    output logic [drt_pkg::ROW_W-1:0]          refresh_row,
    output logic [drt_pkg::NUM_BANKS-1:0]      bank_open,
    output logic [drt_pkg::NUM_BANKS-1:0]      bank_precharging
);
    drt_cmd_if cmd ();

    drt_cmd_decode u_decode
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cke     (cke),
        .cs_n    (cs_n),
        .ras_n   (ras_n),
        .cas_n   (cas_n),
        .we_n    (we_n),
        .ba      (ba),
        .a10     (a10),
        .cmd     (cmd)
    );

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    drt_pkg::drt_state_t         state;
    drt_pkg::drt_state_t         next_state;
    logic                        next_slow;
    logic [drt_pkg::TMR_W-1:0]   rfc_cnt;
    logic [drt_pkg::REFI_W-1:0]  refi_cnt;

    wire running = (state == drt_pkg::ST_RUN);
    wire any_open = |bank_open;
    // Busy precharge timers or refresh keep self-refresh out
    wire all_idle = !any_open && !(|bank_precharging) && !refresh_busy;
    wire do_refresh = running && cmd.is_refresh;
    wire do_sref = running && cmd.is_sref_entry && all_idle;
    wire do_pd = running && cmd.is_pd_entry;

    // Next power state
    always_comb
    begin
        next_state = state;
        case (state)
            drt_pkg::ST_RUN:
            begin
                // enter only with all banks idle
                if (do_sref)
                    next_state = drt_pkg::ST_SREF;
                else if (do_pd && any_open)
                    next_state = drt_pkg::ST_APD;
                // NOP with CKE low enters power-down
                else if (do_pd)
                    next_state = drt_pkg::ST_PPD;
            end
            // only CKE is watched in self-refresh
            drt_pkg::ST_SREF:
            begin
                if (cmd.is_cke_rise)
                    next_state = drt_pkg::ST_RUN;
            end
            default:
            begin
                if (cmd.is_cke_rise)
                    next_state = drt_pkg::ST_RUN;
            end
        endcase
    end

    // exit speed latched at active power-down entry
    assign next_slow = (next_state == drt_pkg::ST_APD)
                     ? (running ? active_pd_exit_select_bit : slow_exit_pd)
                     : 1'b0;

    // State and state-derived outputs
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state <= drt_pkg::ST_RUN;
            in_sref <= 1'b0;
            in_pd <= 1'b0;
            active_pd <= 1'b0;
            slow_exit_pd <= 1'b0;
        end
        else
        begin
            state <= next_state;
            in_sref <= (next_state == drt_pkg::ST_SREF);
            in_pd <= (next_state == drt_pkg::ST_PPD)
                  || (next_state == drt_pkg::ST_APD);
            active_pd <= (next_state == drt_pkg::ST_APD);
            slow_exit_pd <= next_slow;
        end
    end

    // ----------------------------------------------------------------
    // Buffers, DLL and termination
    // ----------------------------------------------------------------
    // DLL stays up only in fast-exit active power-down
    wire next_dll = (next_state == drt_pkg::ST_RUN)
                 || ((next_state == drt_pkg::ST_APD) && !next_slow);
    // termination dropped in self-refresh regardless of pin
    wire next_odt = odt && (next_state != drt_pkg::ST_SREF);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dll_enabled <= 1'b1;
            input_buffers_on <= 1'b1;
            odt_term_on <= 1'b0;
        end
        else
        begin
            dll_enabled <= next_dll;
            // command buffers off in every low-power state
            input_buffers_on <= (next_state == drt_pkg::ST_RUN);
            odt_term_on <= next_odt;
        end
    end

    // ----------------------------------------------------------------
    // Per-bank open rows and precharge timers
    // ----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < drt_pkg::NUM_BANKS; b++)
        begin : g_bank
            logic [drt_pkg::TMR_W-1:0] tmr;
            logic [drt_pkg::TMR_W-1:0] next_tmr;
            wire hit = (cmd.bank == drt_pkg::BANK_W'(b));
            wire pre_hit = running && cmd.is_precharge
                        && (cmd.pre_all || hit);
            wire act_hit = running && cmd.is_activate && hit;

            // latest precharge reloads with its own period
            assign next_tmr = pre_hit
                ? (cmd.pre_all ? drt_pkg::RPALL_CYC_V : drt_pkg::RP_CYC_V)
                : ((tmr != drt_pkg::TMR_RST) ? tmr - 4'h1 : tmr);

            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    tmr <= drt_pkg::TMR_RST;
                    bank_precharging[b] <= 1'b0;
                    bank_open[b] <= 1'b0;
                end
                else
                begin
                    tmr <= next_tmr;
                    bank_precharging[b] <= (next_tmr != drt_pkg::TMR_RST);
                    if (pre_hit || do_refresh)
                        bank_open[b] <= 1'b0;
                    else if (act_hit)
                        bank_open[b] <= 1'b1;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Refresh engine
    // ----------------------------------------------------------------
    // The self-refresh timer uses sys_clk; a stopped clock stalls it
    wire sref_tick = in_sref && (refi_cnt == drt_pkg::REFI_LAST);
    wire row_step = do_refresh || sref_tick;
    wire [drt_pkg::TMR_W-1:0] next_rfc = do_refresh ? drt_pkg::RFC_CYC_V
        : ((rfc_cnt != drt_pkg::TMR_RST) ? rfc_cnt - 4'h1 : rfc_cnt);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rfc_cnt <= drt_pkg::TMR_RST;
            refresh_busy <= 1'b0;
        end
        else
        begin
            rfc_cnt <= next_rfc;
            refresh_busy <= (next_rfc != drt_pkg::TMR_RST);
        end
    end

    // Self-refresh interval divider
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !in_sref || sref_tick)
            refi_cnt <= drt_pkg::REFI_RST;
        else
            refi_cnt <= refi_cnt + 8'h01;
    end

    // internal row counter, wraps after the last row
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            refresh_row <= drt_pkg::ROW_RST;
        else if (row_step)
            refresh_row <= (refresh_row == drt_pkg::ROW_LAST)
                         ? drt_pkg::ROW_RST : refresh_row + 14'h0001;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_bank_prechg;
        @(posedge sys_clk) disable iff (!rst_n)
        (running && cmd.is_precharge && (cmd.pre_all || cmd.bank == 3'h0))
            |=> bank_precharging[0] && !bank_open[0];
    endproperty
    a_bank_prechg: assert property (p_bank_prechg)
        else $error("bank 0 precharge not timed");

    property p_rfc_busy;
        @(posedge sys_clk) disable iff (!rst_n)
        do_refresh |=> refresh_busy [*2];
    endproperty
    a_rfc_busy: assert property (p_rfc_busy)
        else $error("refresh busy shorter than cycle time");

    property p_rfc_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        do_refresh |=> (bank_open == 8'h00);
    endproperty
    a_rfc_idle: assert property (p_rfc_idle)
        else $error("bank open after refresh");

    property p_row_inc;
        @(posedge sys_clk) disable iff (!rst_n)
        (do_refresh && refresh_row != drt_pkg::ROW_LAST)
            |=> refresh_row == $past(refresh_row) + 14'h0001;
    endproperty
    a_row_inc: assert property (p_row_inc)
        else $error("row counter did not advance");

    property p_sref_entry;
        @(posedge sys_clk) disable iff (!rst_n)
        do_sref |=> in_sref && !odt_term_on && !dll_enabled;
    endproperty
    a_sref_entry: assert property (p_sref_entry)
        else $error("self-refresh not entered");

    property p_sref_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_sref && !cke) |=> in_sref;
    endproperty
    a_sref_hold: assert property (p_sref_hold)
        else $error("self-refresh left with CKE low");

    property p_apd_kind;
        @(posedge sys_clk) disable iff (!rst_n)
        (do_pd && !do_sref && any_open)
            |=> active_pd && in_pd
                && (slow_exit_pd == $past(active_pd_exit_select_bit));
    endproperty
    a_apd_kind: assert property (p_apd_kind)
        else $error("active power-down kind wrong");

    property p_pd_dll;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_pd && (!active_pd || slow_exit_pd))
            |-> !dll_enabled && !input_buffers_on;
    endproperty
    a_pd_dll: assert property (p_pd_dll)
        else $error("DLL or buffers on in power-down");

    property p_pd_exit;
        @(posedge sys_clk) disable iff (!rst_n)
        (in_pd && $rose(cke)) |=> !in_pd && input_buffers_on;
    endproperty
    a_pd_exit: assert property (p_pd_exit)
        else $error("power-down not exited");

    c_sref: cover property (@(posedge sys_clk) disable iff (!rst_n)
        in_sref ##1 !in_sref);
    c_apd_slow: cover property (@(posedge sys_clk) disable iff (!rst_n)
        active_pd && slow_exit_pd);
    c_ppd: cover property (@(posedge sys_clk) disable iff (!rst_n)
        in_pd && !active_pd);
    c_refresh: cover property (@(posedge sys_clk) disable iff (!rst_n)
        do_refresh ##4 do_refresh);
endmodule
`default_nettype wire

/* File: shared/drt_cmd_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Decoded command strobes, one cycle each, plus bank and pre_all copied straight from the pins
// ----------------------------------------------------------------
interface drt_cmd_if;
    logic                       is_refresh;
    logic                       is_sref_entry;
    logic                       is_pd_entry;
    logic                       is_cke_rise;
    logic                       is_activate;
    logic                       is_precharge;
    logic                       pre_all;
    logic [drt_pkg::BANK_W-1:0] bank;

    modport dec
    (
        output is_refresh, is_sref_entry, is_pd_entry, is_cke_rise,
        output is_activate, is_precharge, pre_all, bank
    );
    modport core
    (
        input is_refresh, is_sref_entry, is_pd_entry, is_cke_rise,
        input is_activate, is_precharge, pre_all, bank
    );
endinterface
`default_nettype wire

/* File: shared/drt_pkg.sv */
// What this block does
// - Each bank's tRP or tRPall runs from its latest precharge.
// - Auto-refresh: CS, RAS, CAS low, WE high, CKE high; no address.
// - Refresh rows come from the internal counter, not the address bus.
// - Refresh leaves banks idle; tRFC before activate or refresh (only flagged on refresh_busy; neither is held off).
// - Self-refresh: refresh code as CKE falls, banks idle, ODT off.
// - In self-refresh CKE stays low and all other inputs are ignored (except sys_clk, which still times the internal refreshes).
// - Precharge power-down if banks idle, else active; bit picks exit.
// - Power-down keeps only clock, ODT, CKE; DLL off unless fast exit.
package drt_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_RP_NS       = 15;
    localparam int T_RPALL_NS    = 15;
    localparam int T_RFC_NS      = 130;
    localparam int T_REFI_NS     = 7800;
    // Least times round up
    localparam int RP_CYC    = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RPALL_CYC = (T_RPALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC_CYC   = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest interval rounds down
    localparam int REFI_CYC  = T_REFI_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int TMR_W      = 4;
    localparam int REFI_W     = 8;
    localparam int NUM_BANKS  = 8;
    localparam int BANK_W     = 3;
    localparam int ROW_W      = 14;
    localparam int ROWS_TOTAL = 8392;

    localparam logic [TMR_W-1:0]  RP_CYC_V    = TMR_W'(RP_CYC);
    localparam logic [TMR_W-1:0]  RPALL_CYC_V = TMR_W'(RPALL_CYC);
    localparam logic [TMR_W-1:0]  RFC_CYC_V   = TMR_W'(RFC_CYC);
    localparam logic [REFI_W-1:0] REFI_LAST   = REFI_W'(REFI_CYC - 1);
    localparam logic [ROW_W-1:0]  ROW_LAST    = ROW_W'(ROWS_TOTAL - 1);

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [TMR_W-1:0]  TMR_RST  = 4'h0;
    localparam logic [REFI_W-1:0] REFI_RST = 8'h00;
    localparam logic [ROW_W-1:0]  ROW_RST  = 14'h0000;

    // Power states of the device
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SREF,
        ST_PPD,
        ST_APD
    } drt_state_t;

endpackage

/* File: tb/drt_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module drt_ctrl_model
(
    // Clock
    input  wire logic                  sys_clk,
    // Command pins
    output logic                       cke,
    output logic                       cs_n,
    output logic                       ras_n,
    output logic                       cas_n,
    output logic                       we_n,
    output logic                       odt,
    output logic [drt_pkg::BANK_W-1:0] ba,
    output logic                       a10
);
    // ----------------------------------------------------------------
    // Pin driving
    // ----------------------------------------------------------------
    // Power-up: NOP with clock enable high
    initial
    begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        odt = 1'b0;
        ba = 3'h0;
        a10 = 1'b0;
    end

    // no read spacing needed
    // One command, launched just after an edge
    task automatic drive(input logic k, input logic [3:0] code,
                         input logic [2:0] b, input logic all);
        @(posedge sys_clk);
        #1;
        cke = k;
        {cs_n, ras_n, cas_n, we_n} = code;
        ba = b;
        a10 = all;
    endtask

    // NOP while settling
    // Address toggles so a stale value is never mistaken for a held one
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            {cs_n, ras_n, cas_n, we_n} = 4'h7;
            ba = ~ba;
            a10 = ~a10;
        end
    endtask

    task automatic set_odt(input logic v);
        @(posedge sys_clk);
        #1;
        odt = v;
    endtask
endmodule
`default_nettype wire

/* File: tb/drt_timing_core_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) chk(32'(act), 32'(exp))
module drt_timing_core_tb;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam logic [3:0] NOP = 4'h7;
    localparam logic [3:0] REF = 4'h1;
    localparam logic [3:0] ACT = 4'h3;
    localparam logic [3:0] PRE = 4'h2;
    localparam logic [3:0] DES = 4'h8;
    logic        sys_clk;
    logic        rst_n;
    logic        sel_bit;
    logic        cke, cs_n, ras_n, cas_n, we_n, odt, a10;
    logic [2:0]  ba;
    logic        in_sref, in_pd, active_pd, slow_exit_pd;
    logic        dll_enabled, input_buffers_on, odt_term_on;
    logic        refresh_busy;
    logic [13:0] refresh_row;
    logic [7:0]  bank_open;
    logic [7:0]  bank_precharging;
    int          num_errors = 0;
    int          check_count = 0;

    drt_ctrl_model ctrl_i (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba),
        .a10(a10));

    drt_timing_core drt_timing_core_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .odt(odt), .ba(ba), .a10(a10),
        .active_pd_exit_select_bit(sel_bit), .in_sref(in_sref),
        .in_pd(in_pd), .active_pd(active_pd), .slow_exit_pd(slow_exit_pd),
        .dll_enabled(dll_enabled), .input_buffers_on(input_buffers_on),
        .odt_term_on(odt_term_on), .refresh_busy(refresh_busy),
        .refresh_row(refresh_row), .bank_open(bank_open),
        .bank_precharging(bank_precharging));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Address pins carry junk, banks must not notice
    task automatic t_refresh();
        logic [13:0] row0;
        logic [13:0] exp_row;
        row0 = refresh_row;
        // Counter wraps after the last row
        exp_row = (row0 == drt_pkg::ROW_LAST) ? 14'h0000 : row0 + 14'h0001;
        ctrl_i.drive(1'b1, REF, 3'h5, 1'b1);
        ctrl_i.idle(1);
        `CHK(refresh_busy, 1'b1);
        `CHK(refresh_row, exp_row);
        `CHK(bank_precharging, 8'h00);
        ctrl_i.idle(1);
        `CHK(refresh_busy, 1'b1);
        ctrl_i.idle(1);
        `CHK(refresh_busy, 1'b0);
        $display("Test refresh done");
    endtask

    // Row counter must wrap after the last row, not at a power of two
    task automatic t_wrap();
        for (int i = 0; i < 8400 && refresh_row !== drt_pkg::ROW_LAST; i++)
            t_refresh();
        t_refresh();
        `CHK(refresh_row, 14'h0000);
        $display("Test wrap done");
    endtask

    task automatic t_banks();
        ctrl_i.drive(1'b1, ACT, 3'h3, 1'b0);
        ctrl_i.drive(1'b1, ACT, 3'h6, 1'b0);
        ctrl_i.idle(1);
        `CHK(bank_open, 8'h48);
        ctrl_i.drive(1'b1, PRE, 3'h3, 1'b0);
        ctrl_i.idle(1);
        `CHK(bank_open, 8'h40);
        `CHK(bank_precharging, 8'h08);
        ctrl_i.drive(1'b1, PRE, 3'h0, 1'b1);
        ctrl_i.idle(1);
        `CHK(bank_open, 8'h00);
        `CHK(bank_precharging, 8'hff);
        ctrl_i.idle(1);
        `CHK(bank_precharging, 8'h00);
        $display("Test banks done");
    endtask

    task automatic t_sref();
        logic [13:0] row0;
        ctrl_i.set_odt(1'b1);
        ctrl_i.idle(1);
        `CHK(odt_term_on, 1'b1);
        ctrl_i.set_odt(1'b0);
        ctrl_i.idle(2);
        ctrl_i.drive(1'b0, REF, 3'h0, 1'b0);
        ctrl_i.idle(1);
        `CHK({in_sref, dll_enabled, input_buffers_on}, 3'b100);
        ctrl_i.drive(1'b0, ACT, 3'h1, 1'b0);
        ctrl_i.idle(1);
        `CHK(bank_open, 8'h00);
        row0 = refresh_row;
        ctrl_i.idle(156);
        `CHK(refresh_row - row0, 14'h0002);
        // Termination request is ignored while in self-refresh
        ctrl_i.set_odt(1'b1);
        ctrl_i.idle(1);
        `CHK(odt_term_on, 1'b0);
        ctrl_i.set_odt(1'b0);
        ctrl_i.drive(1'b1, NOP, 3'h0, 1'b0);
        ctrl_i.idle(1);
        `CHK({in_sref, dll_enabled, input_buffers_on}, 3'b011);
        ctrl_i.idle(3);
        $display("Test self refresh done");
    endtask

    // Precharge or active power-down, fast or slow exit
    task automatic t_pdown(input logic open, input logic sel);
        sel_bit = sel;
        if (open)
            ctrl_i.drive(1'b1, ACT, 3'h2, 1'b0);
        ctrl_i.drive(1'b0, open ? NOP : DES, 3'h0, 1'b0);
        ctrl_i.idle(1);
        `CHK({in_pd, active_pd, slow_exit_pd}, {1'b1, open, open & sel});
        `CHK({dll_enabled, input_buffers_on}, {open & !sel, 1'b0});
        ctrl_i.drive(1'b1, NOP, 3'h0, 1'b0);
        ctrl_i.idle(1);
        `CHK({in_pd, dll_enabled, input_buffers_on}, 3'b011);
        `CHK(bank_open, {5'h00, open, 2'h0});
        ctrl_i.idle(3);
        ctrl_i.drive(1'b1, PRE, 3'h2, 1'b0);
        ctrl_i.idle(2);
        $display("Test power-down done");
    endtask

    // Open row blocks self-refresh and must not fall into power-down
    task automatic t_sref_refused();
        ctrl_i.drive(1'b1, ACT, 3'h4, 1'b0);
        ctrl_i.drive(1'b0, REF, 3'h0, 1'b0);
        ctrl_i.idle(1);
        `CHK({in_sref, in_pd}, 2'b00);
        ctrl_i.drive(1'b1, NOP, 3'h0, 1'b0);
        ctrl_i.drive(1'b1, PRE, 3'h4, 1'b0);
        ctrl_i.idle(2);
        $display("Test refused entry done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        sel_bit = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        `CHK({dll_enabled, input_buffers_on, in_sref, in_pd}, 4'hc);
        `CHK({refresh_row, bank_open}, 22'h000000);
        ctrl_i.idle(2);
        t_refresh();
        t_banks();
        t_sref();
        t_pdown(1'b0, 1'b1);
        t_pdown(1'b1, 1'b0);
        t_pdown(1'b1, 1'b1);
        t_sref_refused();
        t_wrap();
        end_of_test();
    end

    // Wrap test dominates the run at about 34k cycles
    initial
    begin
        #(60000 * 100);
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
